/* File: verilog/eac_pkg.sv */
// Package for the effective-address calculation block: modes, sizes, requests, results.
// Assumes a single core clock and a decoder that presents one request per cycle.
package eac_pkg;

	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;

	// Addressing modes, one-hot
	typedef enum logic [7:0] {
		EAC_REG_DIRECT = 8'h01,
		EAC_REG_IND    = 8'h02,
		EAC_DISP       = 8'h04,
		EAC_POSTINC    = 8'h08,
		EAC_PREDEC     = 8'h10,
		EAC_ABS        = 8'h20,
		EAC_IMM        = 8'h40,
		EAC_PC_REL     = 8'h80
	} eac_mode_e;

	// Extension field widths
	typedef enum logic [1:0] {
		EAC_EXT8  = 2'h0,
		EAC_EXT16 = 2'h1,
		EAC_EXT24 = 2'h2,
		EAC_EXT32 = 2'h3
	} eac_ext_e;

	// Operand sizes
	typedef enum logic [1:0] {
		EAC_BYTE = 2'h0,
		EAC_WORD = 2'h1,
		EAC_LONG = 2'h2
	} eac_size_e;

	// Instruction classes that limit the legal modes
	typedef enum logic [2:0] {
		EAC_CLS_ALU      = 3'h0,
		EAC_CLS_TRANSFER = 3'h1,
		EAC_CLS_BIT      = 3'h2,
		EAC_CLS_BRANCH   = 3'h3,
		EAC_CLS_JUMP     = 3'h4,
		EAC_CLS_IMPLICIT = 3'h5,
		EAC_CLS_TRAP     = 3'h6
	} eac_cls_e;

	localparam logic [7:0]  RESET_MODE    = 8'h01;
	localparam logic [31:0] STEP_BYTE     = 32'h0000_0001;
	localparam logic [31:0] STEP_WORD     = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG     = 32'h0000_0004;
	localparam logic [31:0] ABS8_UPPER    = 32'hffff_ff00;
	localparam logic [7:0]  PROG_UPPER    = 8'h00;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
	localparam int          CALC_CYCLES   = 1;

	// Request from the instruction decoder
	typedef struct packed {
		logic        valid;
		eac_cls_e    cls;
		logic [7:0]  mode;
		logic        mem_indirect;
		eac_size_e   size;
		eac_ext_e    ext_w;
		logic [31:0] ext;
		logic [2:0]  areg_field;
		logic [3:0]  dreg_field;
		logic        dreg_4bit;
		logic [23:0] pc_next;
		logic        normal_mode;
		logic [2:0]  opc_imm;
		logic        bit_from_reg;
	} eac_req_s;

	// Result to bus unit and register file
	typedef struct packed {
		logic        valid;
		logic        illegal;
		logic        is_mem;
		logic        is_branch;
		logic        fetch_indirect;
		logic [31:0] ea;
		logic [31:0] imm;
		logic [2:0]  bit_num;
		logic [1:0]  trap_vec;
		logic [2:0]  dreg_sel;
		logic [1:0]  dreg_part;
		logic        wb_en;
		logic [2:0]  wb_sel;
		logic [31:0] wb_data;
	} eac_res_s;

endpackage : eac_pkg

/* File: verilog/eac_top.sv */
// Addressing-mode decode and effective-address calculation.
// Assumes the register file answers areg_sel/dreg_sel in the same cycle.
// Operation
// - Address register from 3-bit field; data register from 3 or 4-bit field.
// - Extension of 8, 16 or 32 bits serves as immediate, absolute or displacement.
// - Register direct selects byte, word or longword general register.
// - Register indirect: register holds address; program address upper 8 bits zero.
// - Displacement added to register; 16-bit displacement sign-extended first.
// - Post-increment uses old address, then add_small_const_op 1, 2 or 4 back.
// - Pre-decrement subtracts 1, 2 or 4 first, uses and writes result.
// - 8-bit absolute address gets all-ones upper bits.
// - 16-bit absolute address is sign-extended.
// - 32-bit absolute reaches all; 24-bit absolute is program address, upper zero.
// - Immediates used directly; bit-number immediate 3 bits, trap vector 2 bits.
// - Small-constant add/sub and step ops take immediate from opcode.
// - PC-relative displacement sign-extended to 24 bits, added to PC, upper zero.
// - PC used is next instruction address; targets should be even.
// - Memory indirect zero-extends 8-bit address, fetches longword with top byte zero.
// - Word, longword and branch addresses have lowest bit forced to zero.
// - ALU takes register direct and immediate; transfers all but PC-rel, memory indirect.
// - Bit ops use direct, indirect or absolute; bit number immediate or register.
// - PC-relative for branch, implicit and trap classes; memory indirect for jumps only.
// - Normal mode ignores upper 8 bits, driving a 16-bit address.
`timescale 1ns/10ps

module eac_top (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	// Decoder request
	input  wire eac_pkg::eac_req_s req,
	// Register file read
	output wire logic [2:0]       areg_sel,
	input  wire logic [31:0]      areg_val,
	// Memory-indirect longword fetched by bus unit
	input  wire logic [31:0]      ind_data,
	// Result
	output eac_pkg::eac_res_s     res
);

	// Sign/zero extension of the extension field
	function automatic logic [31:0] sext_ext(input logic [31:0] x, input eac_pkg::eac_ext_e w);
		logic [31:0] r;
		r = x;
		if (w == eac_pkg::EAC_EXT8)
			r = {{24{x[7]}}, x[7:0]};
		else if (w == eac_pkg::EAC_EXT16)
			r = {{16{x[15]}}, x[15:0]};
		else if (w == eac_pkg::EAC_EXT24)
			r = {eac_pkg::PROG_UPPER, x[23:0]};
		return r;
	endfunction : sext_ext

	// Word alignment and normal-mode truncation, used for data and branch targets
	function automatic logic [31:0] shape(input logic [31:0] a, input logic even, input logic nm);
		logic [31:0] r;
		r = {a[31:1], a[0] & ~even};
		if (nm)
			r = {16'h0000, r[15:0]};
		return r;
	endfunction : shape

	wire logic [7:0]  m          = req.mode;
	wire logic        is_direct  = m == eac_pkg::EAC_REG_DIRECT;
	wire logic        is_ind     = m == eac_pkg::EAC_REG_IND;
	wire logic        is_disp    = m == eac_pkg::EAC_DISP;
	wire logic        is_post    = m == eac_pkg::EAC_POSTINC;
	wire logic        is_pre     = m == eac_pkg::EAC_PREDEC;
	wire logic        is_abs     = m == eac_pkg::EAC_ABS;
	wire logic        is_imm     = m == eac_pkg::EAC_IMM;
	wire logic        is_pcrel   = m == eac_pkg::EAC_PC_REL;
	wire logic        is_memind  = req.mem_indirect;

	assign areg_sel = req.areg_field;

	// Step for auto-increment/decrement
	wire logic [31:0] step = (req.size == eac_pkg::EAC_LONG) ? eac_pkg::STEP_LONG :
	                         (req.size == eac_pkg::EAC_WORD) ? eac_pkg::STEP_WORD :
	                                                           eac_pkg::STEP_BYTE;
	wire logic [31:0] reg_plus  = areg_val + step;
	wire logic [31:0] reg_minus = areg_val - step;

	wire logic [31:0] ext_x    = sext_ext(req.ext, req.ext_w);
	wire logic [31:0] disp_x   = (req.ext_w == eac_pkg::EAC_EXT32) ? req.ext
	                           : {{16{req.ext[15]}}, req.ext[15:0]};
	wire logic [31:0] disp_sum = areg_val + disp_x;
	wire logic [31:0] abs_addr = (req.ext_w == eac_pkg::EAC_EXT8)
	                           ? (eac_pkg::ABS8_UPPER | {24'h000000, req.ext[7:0]})
	                           : ext_x;
	wire logic [23:0] pc_disp  = (req.ext_w == eac_pkg::EAC_EXT8) ? {{16{req.ext[7]}}, req.ext[7:0]}
	                           : {{8{req.ext[15]}}, req.ext[15:0]};
	wire logic [23:0] pc_tgt   = req.pc_next + pc_disp;
	wire logic [31:0] ind_ptr  = {24'h000000, req.ext[7:0]};

	// Legality per instruction class
	wire logic mode_ok =
		(req.cls == eac_pkg::EAC_CLS_ALU)      ? (is_direct | is_imm) && !is_memind :
		(req.cls == eac_pkg::EAC_CLS_TRANSFER) ? !is_pcrel && !is_memind :
		(req.cls == eac_pkg::EAC_CLS_BIT)      ? (is_direct | is_ind | is_abs) && !is_memind :
		(req.cls == eac_pkg::EAC_CLS_BRANCH)   ? is_pcrel && !is_memind :
		(req.cls == eac_pkg::EAC_CLS_JUMP)     ? (is_memind | is_ind | is_abs) :
		!is_memind;

	wire logic even_req  = req.size != eac_pkg::EAC_BYTE;
	wire logic prog_addr = req.cls == eac_pkg::EAC_CLS_JUMP;

	// Raw address selection
	wire logic [31:0] raw_ea =
		is_memind ? ind_ptr :
		is_pcrel  ? {eac_pkg::PROG_UPPER, pc_tgt} :
		is_disp   ? disp_sum :
		is_pre    ? reg_minus :
		is_abs    ? abs_addr :
		(is_ind && prog_addr) ? {eac_pkg::PROG_UPPER, areg_val[23:0]} :
		areg_val;

	wire logic branch_like = is_pcrel | prog_addr;
	wire logic [31:0] next_ea = shape(raw_ea, even_req | branch_like | is_memind, req.normal_mode);

	// Immediate source: opcode-implicit or extension
	wire logic implicit_imm = req.cls == eac_pkg::EAC_CLS_IMPLICIT;
	wire logic [31:0] next_imm = implicit_imm ? {29'h0, req.opc_imm}
	                           : ext_x;

	wire logic [2:0] next_dsel  = req.dreg_4bit ? req.dreg_field[2:0] : req.dreg_field[2:0];
	// Part: 0 low byte/word half, 1 high byte, 2 upper word, 3 full
	// A 3-bit field has no half selector, so its top bit is ignored
	wire logic       dreg_hi    = req.dreg_4bit & req.dreg_field[3];
	wire logic [1:0] next_dpart =
		(req.size == eac_pkg::EAC_LONG) ? 2'h3 :
		(req.size == eac_pkg::EAC_WORD) ? (dreg_hi ? 2'h2 : 2'h0) :
		(dreg_hi ? 2'h0 : 2'h1);

	wire logic next_wb = (is_post | is_pre) && mode_ok && req.valid;

	// Memory-indirect fetched target: top byte treated as zero
	wire logic [31:0] ind_tgt = shape({eac_pkg::PROG_UPPER, ind_data[23:0]}, 1'b1, req.normal_mode);

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			res <= '0;
		end else begin
			res.valid          <= req.valid;
			res.illegal        <= req.valid & ~mode_ok;
			res.is_mem         <= ~(is_direct | is_imm | is_pcrel);
			res.is_branch      <= branch_like | is_memind;
			res.fetch_indirect <= is_memind;
			res.ea             <= next_ea;
			res.imm            <= is_memind ? ind_tgt : next_imm;
			res.bit_num        <= req.bit_from_reg ? areg_val[2:0] : req.opc_imm;
			res.trap_vec       <= req.opc_imm[1:0];
			res.dreg_sel       <= next_dsel;
			res.dreg_part      <= next_dpart;
			res.wb_en          <= next_wb;
			res.wb_sel         <= req.areg_field;
			res.wb_data        <= is_post ? reg_plus : reg_minus;
		end
	end

endmodule : eac_top

/* File: testbench/eac_regfile_model.sv */
// Register file and bus unit seen by the address calculation block.
// Assumes reads are answered in the cycle the selector is shown.
`timescale 1ns/10ps
module eac_regfile_model (
	// Register read
	input  wire logic [2:0]  areg_sel,
	output wire logic [31:0] areg_val,
	// Indirect longword
	output wire logic [31:0] ind_data
);
	// Even contents, as software keeps them for auto-stepping
	assign areg_val = 32'h0000_1000 | {21'h0, areg_sel, 8'h00};
	// Odd, non-zero top byte: the block must clear both
	assign ind_data = 32'hab12_3457;
endmodule : eac_regfile_model

/* File: testbench/eac_top_assertions.sv */
// Port checks for the address calculation block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module eac_top_assertions (
	// Clock and reset
	input wire logic              mclk,
	input wire logic              resetn,
	// Block ports
	input wire eac_pkg::eac_req_s req,
	input wire logic [2:0]        areg_sel,
	input wire logic [31:0]       areg_val,
	input wire logic [31:0]       ind_data,
	input wire eac_pkg::eac_res_s res
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire xfer = req.valid && req.cls == eac_pkg::EAC_CLS_TRANSFER && !req.normal_mode;
	a_sel_follow: assert property (areg_sel == req.areg_field) else $error("selector differs");
	a_answer_latency: assert property (req.valid |=> res.valid) else $error("no answer");
	a_no_request: assert property (!req.valid |=> !res.valid) else $error("spurious answer");
	a_post_step: assert property (xfer && req.mode == eac_pkg::EAC_POSTINC && req.size == eac_pkg::EAC_LONG
		|=> res.wb_en && res.wb_data == $past(areg_val) + 32'h4) else $error("post step wrong");
	a_pre_step: assert property (xfer && req.mode == eac_pkg::EAC_PREDEC && req.size == eac_pkg::EAC_BYTE
		|=> res.ea[23:0] == $past(areg_val[23:0]) - 24'h1) else $error("pre step wrong");
	a_refused_nowb: assert property (res.illegal |-> !res.wb_en) else $error("refused but written");
	a_alu_refuse: assert property (req.valid && req.cls == eac_pkg::EAC_CLS_ALU && req.mode == eac_pkg::EAC_DISP
		|=> res.illegal) else $error("alu mode accepted");
	a_branch_even: assert property (req.valid && req.cls == eac_pkg::EAC_CLS_BRANCH && req.mode == eac_pkg::EAC_PC_REL
		|=> res.ea[31:24] == 8'h00 && !res.ea[0]) else $error("branch target bad");
	a_normal_upper: assert property (req.valid && req.normal_mode |=> res.ea[31:16] == 16'h0)
		else $error("normal mode upper bits");
	a_trap_vec: assert property (req.valid && req.cls == eac_pkg::EAC_CLS_TRAP
		|=> res.trap_vec == $past(req.opc_imm[1:0])) else $error("trap vector wrong");
	c_post: cover property (xfer && req.mode == eac_pkg::EAC_POSTINC);
	c_refused: cover property (res.illegal);
	c_branch: cover property (req.valid && req.mode == eac_pkg::EAC_PC_REL);
endmodule : eac_top_assertions
bind eac_top eac_top_assertions u_chk (.mclk(mclk), .resetn(resetn), .req(req), .areg_sel(areg_sel),
	.areg_val(areg_val), .ind_data(ind_data), .res(res));

/* File: testbench/effective_address_calc_bench.sv */
// Directed bench for the address calculation block.
// Assumes a one-cycle answer latency and the register model beside it.
`timescale 1ns/10ps
module effective_address_calc_bench;
	logic              mclk = 1'b0;
	logic              resetn = 1'b0;
	eac_pkg::eac_req_s req = '0;
	logic [2:0]        areg_sel;
	logic [31:0]       areg_val;
	logic [31:0]       ind_data;
	eac_pkg::eac_res_s res;
	int                mismatches = 0;
	int                n_compared = 0;
	always #50 mclk = ~mclk;
	eac_top u_dut (.mclk(mclk), .resetn(resetn), .req(req), .areg_sel(areg_sel), .areg_val(areg_val),
		.ind_data(ind_data), .res(res));
	eac_regfile_model u_regs (.areg_sel(areg_sel), .areg_val(areg_val), .ind_data(ind_data));
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// Register 2 always, so its contents are 32'h1200
	task automatic go(input eac_pkg::eac_cls_e c, input logic [7:0] m, input eac_pkg::eac_size_e s,
		input eac_pkg::eac_ext_e w, input logic [31:0] x, input logic mi = 1'b0, input logic nm = 1'b0,
		input logic [2:0] oi = 3'h0);
		eac_pkg::eac_req_s r;
		r = '{valid: 1'b1, cls: c, mode: m, mem_indirect: mi, size: s, ext_w: w, ext: x, areg_field: 3'h2,
			pc_next: 24'h001000, normal_mode: nm, opc_imm: oi, default: '0};
		@(posedge mclk) req <= r;
		@(posedge mclk) req <= '0;
		#1;
	endtask : go
	task automatic t_autostep();
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_POSTINC, eac_pkg::EAC_LONG, eac_pkg::EAC_EXT8, 32'h0);
		check("post ea", 32'h0000_1200, res.ea);
		check("post wb", 32'h0000_1204, res.wb_data);
		check("post wb_sel", 32'h2, {29'h0, res.wb_sel});
		for (int i = 0; i < 3; i++) begin
			go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_PREDEC, eac_pkg::eac_size_e'(i), eac_pkg::EAC_EXT8, 32'h0);
			check("pre ea", 32'h0000_1200 - (32'h1 << i), res.ea);
			check("pre wb", 32'h0000_1200 - (32'h1 << i), res.wb_data);
			check("pre wb_en", 32'h1, {31'h0, res.wb_en});
		end
	endtask : t_autostep
	task automatic t_disp_abs();
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_DISP, eac_pkg::EAC_BYTE, eac_pkg::EAC_EXT16, 32'h0000_fff0);
		check("disp16", 32'h0000_11f0, {8'h0, res.ea[23:0]});
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_DISP, eac_pkg::EAC_BYTE, eac_pkg::EAC_EXT32, 32'h0001_0000);
		check("disp32", 32'h0001_1200, {8'h0, res.ea[23:0]});
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_ABS, eac_pkg::EAC_BYTE, eac_pkg::EAC_EXT8, 32'h0000_0035);
		check("abs8", 32'h00ff_ff35, {8'h0, res.ea[23:0]});
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_ABS, eac_pkg::EAC_BYTE, eac_pkg::EAC_EXT16, 32'h0000_8001);
		check("abs16", 32'h00ff_8001, {8'h0, res.ea[23:0]});
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_ABS, eac_pkg::EAC_BYTE, eac_pkg::EAC_EXT32, 32'h00ab_cdef);
		check("abs32", 32'h00ab_cdef, {8'h0, res.ea[23:0]});
		go(eac_pkg::EAC_CLS_JUMP, eac_pkg::EAC_ABS, eac_pkg::EAC_LONG, eac_pkg::EAC_EXT24, 32'h5512_3456);
		check("abs24", 32'h0012_3456, res.ea);
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_ABS, eac_pkg::EAC_WORD, eac_pkg::EAC_EXT16, 32'h0000_8001, 1'b0, 1'b1);
		check("normal ea", 32'h0000_8000, res.ea);
	endtask : t_disp_abs
	task automatic t_branch();
		go(eac_pkg::EAC_CLS_BRANCH, eac_pkg::EAC_PC_REL, eac_pkg::EAC_WORD, eac_pkg::EAC_EXT8, 32'h0000_00fe);
		check("rel8 back", 32'h0000_0ffe, res.ea);
		go(eac_pkg::EAC_CLS_BRANCH, eac_pkg::EAC_PC_REL, eac_pkg::EAC_WORD, eac_pkg::EAC_EXT16, 32'h0000_8000);
		check("rel16 wrap", 32'h00ff_9000, res.ea);
		go(eac_pkg::EAC_CLS_BRANCH, eac_pkg::EAC_PC_REL, eac_pkg::EAC_WORD, eac_pkg::EAC_EXT8, 32'h0000_0003);
		check("rel odd", 32'h0000_1002, res.ea);
		go(eac_pkg::EAC_CLS_JUMP, eac_pkg::EAC_ABS, eac_pkg::EAC_LONG, eac_pkg::EAC_EXT8, 32'h0000_0080, 1'b1);
		check("memind ea", 32'h0000_0080, res.ea);
		check("memind target", 32'h0012_3456, res.imm);
		check("memind flags", 32'h3, {30'h0, res.fetch_indirect, res.is_branch});
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_ABS, eac_pkg::EAC_WORD, eac_pkg::EAC_EXT8, 32'h0000_0080, 1'b1);
		check("xfer memind", 32'h1, {31'h0, res.illegal});
	endtask : t_branch
	task automatic t_classes();
		go(eac_pkg::EAC_CLS_ALU, eac_pkg::EAC_POSTINC, eac_pkg::EAC_WORD, eac_pkg::EAC_EXT8, 32'h0);
		check("alu postinc", 32'h1, {31'h0, res.illegal & ~res.wb_en});
		go(eac_pkg::EAC_CLS_TRANSFER, eac_pkg::EAC_PC_REL, eac_pkg::EAC_WORD, eac_pkg::EAC_EXT8, 32'h0);
		check("xfer pcrel", 32'h1, {31'h0, res.illegal});
		go(eac_pkg::EAC_CLS_ALU, eac_pkg::EAC_IMM, eac_pkg::EAC_LONG, eac_pkg::EAC_EXT32, 32'h89ab_cdef);
		check("alu imm", 32'h89ab_cdef, res.imm);
		go(eac_pkg::EAC_CLS_TRAP, eac_pkg::EAC_IMM, eac_pkg::EAC_BYTE, eac_pkg::EAC_EXT8, 32'h0, 1'b0, 1'b0, 3'h6);
		check("trap vec", 32'h2, {30'h0, res.trap_vec});
		go(eac_pkg::EAC_CLS_BIT, eac_pkg::EAC_REG_IND, eac_pkg::EAC_BYTE, eac_pkg::EAC_EXT8, 32'h0, 1'b0, 1'b0, 3'h5);
		check("bit num", 32'h5, {29'h0, res.bit_num});
	endtask : t_classes
	task automatic t_regs();
		eac_pkg::eac_req_s r;
		r = '{valid: 1'b1, cls: eac_pkg::EAC_CLS_TRANSFER, mode: eac_pkg::EAC_REG_DIRECT, size: eac_pkg::EAC_WORD,
			ext_w: eac_pkg::EAC_EXT8, dreg_field: 4'hd, dreg_4bit: 1'b1, default: '0};
		@(posedge mclk) req <= r;
		@(posedge mclk) req <= '0;
		#1;
		check("dreg sel", 32'h5, {29'h0, res.dreg_sel});
		check("dreg part", 32'h2, {30'h0, res.dreg_part});
		check("direct flags", 32'h4, {29'h0, res.valid, res.is_mem, res.is_branch});
		go(eac_pkg::EAC_CLS_IMPLICIT, eac_pkg::EAC_IMM, eac_pkg::EAC_LONG, eac_pkg::EAC_EXT32, 32'hffff_ffff, 1'b0,
			1'b0, 3'h4);
		check("implicit imm", 32'h4, res.imm);
	endtask : t_regs
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (16) @(posedge mclk);
		#1;
		check("reset res", 32'h0, {31'h0, |res});
		@(posedge mclk) resetn <= 1'b1;
		t_autostep();
		t_disp_abs();
		t_branch();
		t_classes();
		t_regs();
		print_verdict();
	end
endmodule : effective_address_calc_bench
